// file: rcs_cmp.sv
`timescale 1ns/10ps
`default_nettype none
// ************************************************************
// ** nibble pattern comparator
// ************************************************************
module rcs_cmp
  import rcs_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // link
  rcs_dp_if.chk    dp
);
  logic             match_r;
  logic             match_nxt;
  logic [DATA_W/4-1:0] nib_ok;

  genvar gi;
  generate
    for (gi = 0; gi < DATA_W/4; gi++) begin : g_nib
      assign nib_ok[gi] = (dp.data[gi*4 +: 4] == dp.expect_nib);
    end
  endgenerate

  always_comb begin
    match_nxt = match_r;
    if (dp.capture) begin
      match_nxt = &nib_ok;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      match_r <= 1'b0;
    end else begin
      match_r <= match_nxt;
    end
  end

  assign dp.match = match_r;
endmodule // rcs_cmp
`default_nettype wire

// file: rcs_dp_if.sv
`timescale 1ns/10ps
`default_nettype none
// ************************************************************
// ** sequencer to checker / pointer links
// ************************************************************
interface rcs_dp_if;
  import rcs_pkg::*;
  logic [DATA_W-1:0] data;
  logic              capture;
  logic [3:0]        expect_nib;
  logic              match;
  logic              vptr_inc;
  logic              vptr_clr;
  logic [VPTR_W-1:0] vptr;
  modport seq (output data, capture, expect_nib, vptr_inc, vptr_clr,
               input match, vptr);
  modport chk (input data, capture, expect_nib, output match);
  modport ptr (input vptr_inc, vptr_clr, output vptr);
endinterface
`default_nettype wire

// file: rcs_phy_model.sv
`timescale 1ns/10ps
`default_nettype none
module rcs_phy_model
  import rcs_pkg::*;
#(
  parameter int RD_LAT = 6
)(
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              reset,
  // command side
  input  wire logic [1:0]        phy_cmd,
  input  wire logic [ADDR_W-1:0] phy_addr,
  input  wire logic [DATA_W-1:0] phy_wdata,
  // calibration settings and scenario knobs
  input  wire logic [VPTR_W-1:0] read_valid_fifo_wr_ptr,
  input  wire logic [LAT_W-1:0]  read_latency,
  input  wire logic              rdfifo_ptr_reset,
  input  wire logic [VPTR_W-1:0] vptr_need,
  input  wire logic [5:0]        lat_need,
  // read return
  output logic                   rd_valid,
  output logic [DATA_W-1:0]      rd_data
);
  logic [DATA_W-1:0] mem_r [2];
  logic [DATA_W-1:0] dat_r [RD_LAT];
  logic [RD_LAT-1:0] vld_r;
  logic [DATA_W-1:0] last_r;
  logic              lat_ph_r;
  logic              ok;
  // too short a setting returns corrupted data
  assign ok = lat_ph_r ? ({1'b0, read_latency} >= lat_need)
                       : (read_valid_fifo_wr_ptr >= vptr_need);
  always_ff @(posedge ref_clk) begin
    vld_r    <= {vld_r[RD_LAT-2:0], phy_cmd == RCS_CMD_READ};
    dat_r[0] <= ok ? mem_r[phy_addr[0]] : ~mem_r[phy_addr[0]];
    for (int i = 1; i < RD_LAT; i++) begin
      dat_r[i] <= dat_r[i-1];
    end
    if (phy_cmd == RCS_CMD_WRITE) begin
      mem_r[phy_addr[0]] <= phy_wdata;
    end
    if (rd_valid) begin
      last_r <= rd_data;
    end
    if (rdfifo_ptr_reset) begin
      lat_ph_r <= 1'b1;
    end
    if (reset) begin
      vld_r    <= {RD_LAT{1'b0}};
      lat_ph_r <= 1'b0;
      last_r   <= 16'h0000;
    end
  end
  assign rd_valid = vld_r[RD_LAT-1];
  // idle bus shows the inverse of the last beat
  assign rd_data  = rd_valid ? dat_r[RD_LAT-1] : ~last_r;
endmodule // rcs_phy_model
`default_nettype wire

// file: rcs_pkg.sv
package rcs_pkg;

  // ************************************************************
  // ** widths and defaults
  // ************************************************************
  localparam int ADDR_W      = 8;
  localparam int DATA_W      = 16;
  localparam int LAT_W       = 5;
  localparam int VPTR_W      = 4;
  localparam int CNT_W       = 16;

  localparam logic [ADDR_W-1:0] ADDR_PAT_A = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_PAT_B = 8'h01;
  localparam logic [3:0]        NIB_A      = 4'hA;
  localparam logic [3:0]        NIB_B      = 4'h5;

  localparam logic [LAT_W-1:0]  LAT_MAX_DEF    = 5'h1F;
  localparam logic [LAT_W-1:0]  LAT_MIN_DEF    = 5'h02;
  localparam logic [LAT_W-1:0]  LAT_STEP_DOWN  = 5'h01;
  localparam logic [LAT_W-1:0]  LAT_MARGIN     = 5'h03;
  localparam logic [VPTR_W-1:0] VPTR_STEP      = 4'h1;
  localparam logic [VPTR_W-1:0] VPTR_ZERO      = 4'h0;

  // stable wait, 200 us at 125 MHz
  localparam int STABLE_US     = 200;
  localparam int CLK_MHZ       = 125;
  localparam int STABLE_CYC    = STABLE_US * CLK_MHZ;
  localparam int BURST_LEN_DEF = 4;
  localparam int CMP_WAIT_DEF  = 4;
  localparam int FLUSH_CYC_DEF = 32;
  localparam int READ_TO_DEF   = 64;
  localparam logic [CNT_W-1:0]  CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0]  CNT_ONE  = 16'h0001;

  // ************************************************************
  // ** command encoding
  // ************************************************************
  typedef enum logic [1:0] {
    RCS_CMD_NOP   = 2'h0,
    RCS_CMD_WRITE = 2'h1,
    RCS_CMD_READ  = 2'h2
  } rcs_cmd_t;

endpackage

// file: rcs_seq.sv
`timescale 1ns/10ps
`default_nettype none
module rcs_seq
  import rcs_pkg::*;
#(
  parameter int STABLE_CYCLES = STABLE_CYC,
  parameter int BURST_LEN     = BURST_LEN_DEF,
  parameter int HALF_RATE     = 0,
  parameter int CMP_WAIT      = CMP_WAIT_DEF,
  parameter int FLUSH_CYCLES  = FLUSH_CYC_DEF,
  parameter int READ_TIMEOUT  = READ_TO_DEF,
  parameter logic [LAT_W-1:0] LAT_MAX = LAT_MAX_DEF,
  parameter logic [LAT_W-1:0] LAT_MIN = LAT_MIN_DEF
)(
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              reset,
  // controller command side
  input  wire logic [1:0]        ctl_cmd,
  input  wire logic [ADDR_W-1:0] ctl_addr,
  input  wire logic [DATA_W-1:0] ctl_wdata,
  // phy command side
  output logic [1:0]             phy_cmd,
  output logic [ADDR_W-1:0]      phy_addr,
  output logic [DATA_W-1:0]      phy_wdata,
  // read datapath
  input  wire logic              rd_valid,
  input  wire logic [DATA_W-1:0] rd_data,
  output logic [VPTR_W-1:0]      read_valid_fifo_wr_ptr,
  output logic                   rdfifo_wr_en,
  output logic                   rdfifo_ptr_reset,
  output logic                   latency_fifo_rd_en,
  output logic [LAT_W-1:0]       read_latency,
  // status
  output logic                   seq_busy,
  output logic                   cal_success,
  output logic                   cal_fail
);

  // ************************************************************
  // ** states
  // ************************************************************
  typedef enum logic [4:0] {
    S_RESET        = 5'h00,
    S_LOAD_INIT    = 5'h01,
    S_STABLE       = 5'h03,
    S_WR_A         = 5'h02,
    S_WR_A_DATA    = 5'h06,
    S_WR_B         = 5'h07,
    S_WR_B_DATA    = 5'h05,
    S_V_RD_A       = 5'h04,
    S_V_GAP        = 5'h0C,
    S_V_RD_B       = 5'h0D,
    S_V_WAIT       = 5'h0F,
    S_V_CMP        = 5'h0E,
    S_V_CHECK      = 5'h0A,
    S_V_ADD_FULL   = 5'h0B,
    S_V_ADD_HALF   = 5'h09,
    S_V_FIFO_RST   = 5'h08,
    S_V_PASS       = 5'h18,
    S_L_RD_B       = 5'h19,
    S_L_WAIT       = 5'h1B,
    S_L_CMP        = 5'h1A,
    S_L_REDUCE     = 5'h1E,
    S_L_FLUSH      = 5'h1F,
    S_L_WAIT_FLUSH = 5'h1D,
    S_L_MARGIN     = 5'h1C,
    S_DONE         = 5'h14,
    S_FAIL         = 5'h10
  } rcs_state_t;

  localparam int GAP_CYCLES = (BURST_LEN / 2 > 1) ? BURST_LEN / 2 : 1;
  localparam logic [CNT_W-1:0] STABLE_LAST = CNT_W'(STABLE_CYCLES - 1);
  localparam logic [CNT_W-1:0] GAP_LAST    = CNT_W'(GAP_CYCLES - 1);
  localparam logic [CNT_W-1:0] CMP_LAST    = CNT_W'(CMP_WAIT - 1);
  localparam logic [CNT_W-1:0] FLUSH_LAST  = CNT_W'(FLUSH_CYCLES - 1);
  localparam logic [CNT_W-1:0] TO_LAST     = CNT_W'(READ_TIMEOUT - 1);
  localparam logic [LAT_W:0]   LAT_MIN_X   = {1'b0, LAT_MIN};

  rcs_state_t        state_r;
  rcs_state_t        state_nxt;
  logic [CNT_W-1:0]  cnt_r;
  logic [CNT_W-1:0]  cnt_nxt;
  logic [LAT_W-1:0]  lat_r;
  logic [LAT_W-1:0]  lat_nxt;
  logic              pass_b_r;
  logic              pass_b_nxt;
  logic [1:0]        cmd_r;
  logic [1:0]        cmd_nxt;
  logic [ADDR_W-1:0] addr_r;
  logic [ADDR_W-1:0] addr_nxt;
  logic [DATA_W-1:0] wdata_r;
  logic [DATA_W-1:0] wdata_nxt;
  logic [3:0]        exp_nib;
  logic              cap;
  logic              inc;
  logic              fifo_rst;
  logic [LAT_W:0]    lat_sum;
  logic              cnt_hit;

  // ************************************************************
  // ** helpers
  // ************************************************************
  rcs_dp_if dp ();

  rcs_cmp u_cmp (
    .ref_clk (ref_clk),
    .reset   (reset),
    .dp      (dp.chk)
  );

  rcs_vptr u_vptr (
    .ref_clk (ref_clk),
    .reset   (reset),
    .dp      (dp.ptr)
  );

  assign dp.data       = rd_data;
  assign dp.capture    = cap;
  assign dp.expect_nib = exp_nib;
  assign dp.vptr_inc   = inc;
  assign dp.vptr_clr   = 1'b0;

  // ************************************************************
  // ** sequencer
  // ************************************************************
  always_comb begin
    state_nxt  = state_r;
    cnt_nxt    = cnt_r + CNT_ONE;
    lat_nxt    = lat_r;
    pass_b_nxt = pass_b_r;
    cmd_nxt    = RCS_CMD_NOP;
    addr_nxt   = addr_r;
    wdata_nxt  = wdata_r;
    exp_nib    = NIB_A;
    cap        = 1'b0;
    inc        = 1'b0;
    fifo_rst   = 1'b0;
    lat_sum    = {1'b0, lat_r} + {1'b0, LAT_MARGIN};
    cnt_hit    = 1'b0;
    case (state_r)
      S_RESET: begin
        state_nxt = S_LOAD_INIT;
        cnt_nxt   = CNT_ZERO;
      end
      S_LOAD_INIT: begin
        lat_nxt   = LAT_MAX;
        cnt_nxt   = CNT_ZERO;
        state_nxt = S_STABLE;
      end
      S_STABLE: begin
        if (cnt_r == STABLE_LAST) begin
          state_nxt = S_WR_A;
        end
      end
      S_WR_A: begin
        cmd_nxt   = RCS_CMD_WRITE;
        addr_nxt  = ADDR_PAT_A;
        wdata_nxt = {(DATA_W/4){NIB_A}};
        state_nxt = S_WR_A_DATA;
      end
      S_WR_A_DATA: state_nxt = S_WR_B;
      S_WR_B: begin
        cmd_nxt   = RCS_CMD_WRITE;
        addr_nxt  = ADDR_PAT_B;
        wdata_nxt = {(DATA_W/4){NIB_B}};
        state_nxt = S_WR_B_DATA;
      end
      S_WR_B_DATA: state_nxt = S_V_RD_A;
      S_V_RD_A: begin
        cmd_nxt   = RCS_CMD_READ;
        addr_nxt  = ADDR_PAT_A;
        cnt_nxt   = CNT_ZERO;
        state_nxt = S_V_GAP;
      end
      S_V_GAP: begin
        if (cnt_r == GAP_LAST) begin
          state_nxt = S_V_RD_B;
        end
      end
      S_V_RD_B: begin
        cmd_nxt   = RCS_CMD_READ;
        addr_nxt  = ADDR_PAT_B;
        cnt_nxt   = CNT_ZERO;
        state_nxt = S_V_WAIT;
      end
      S_V_WAIT: begin
        // first beat holds address 0 data
        if (rd_valid) begin
          cap       = 1'b1;
          cnt_nxt   = CNT_ZERO;
          state_nxt = S_V_CMP;
        end else if (cnt_r == TO_LAST) begin
          state_nxt = S_V_CHECK;
        end
      end
      S_V_CMP: begin
        cnt_hit = (cnt_r == CMP_LAST);
        if (cnt_r == CNT_ZERO) begin
          pass_b_nxt = dp.match;
        end
        if (rd_valid) begin
          exp_nib = NIB_B;
          cap     = 1'b1;
        end
        if (cnt_hit) begin
          state_nxt = S_V_CHECK;
        end
      end
      S_V_CHECK: begin
        if (pass_b_r && dp.match) begin
          state_nxt = S_V_FIFO_RST;
        end else begin
          inc       = 1'b1;
          state_nxt = S_V_ADD_FULL;
        end
        pass_b_nxt = 1'b0;
      end
      S_V_ADD_FULL: begin
        inc       = 1'b1;
        state_nxt = (HALF_RATE != 0) ? S_V_ADD_HALF : S_V_RD_A;
      end
      S_V_ADD_HALF: begin
        inc       = 1'b1;
        state_nxt = S_V_RD_A;
      end
      S_V_FIFO_RST: begin
        fifo_rst  = 1'b1;
        state_nxt = S_V_PASS;
      end
      S_V_PASS: begin
        lat_nxt   = LAT_MAX;
        state_nxt = S_L_RD_B;
      end
      S_L_RD_B: begin
        cmd_nxt   = RCS_CMD_READ;
        addr_nxt  = ADDR_PAT_B;
        cnt_nxt   = CNT_ZERO;
        state_nxt = S_L_WAIT;
      end
      S_L_WAIT: begin
        exp_nib = NIB_B;
        if (rd_valid) begin
          cap       = 1'b1;
          state_nxt = S_L_CMP;
        end else if (cnt_r == TO_LAST) begin
          state_nxt = S_L_MARGIN;
        end
      end
      S_L_CMP: begin
        state_nxt = dp.match ? S_L_REDUCE : S_L_MARGIN;
      end
      S_L_REDUCE: begin
        lat_nxt   = lat_r - LAT_STEP_DOWN;
        state_nxt = S_L_FLUSH;
      end
      S_L_FLUSH: begin
        cmd_nxt   = RCS_CMD_READ;
        addr_nxt  = ADDR_PAT_A;
        cnt_nxt   = CNT_ZERO;
        state_nxt = S_L_WAIT_FLUSH;
      end
      S_L_WAIT_FLUSH: begin
        if (cnt_r == FLUSH_LAST) begin
          state_nxt = S_L_RD_B;
        end
      end
      S_L_MARGIN: begin
        lat_nxt = lat_sum[LAT_W] ? LAT_MAX : lat_sum[LAT_W-1:0];
        if (lat_sum < LAT_MIN_X) begin
          state_nxt = S_FAIL;
        end else begin
          state_nxt = S_DONE;
        end
      end
      S_DONE: begin
        cnt_nxt   = cnt_r;
        state_nxt = S_DONE;
      end
      S_FAIL: begin
        cnt_nxt   = cnt_r;
        state_nxt = S_FAIL;
      end
      default: state_nxt = S_RESET;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_r  <= S_RESET;
      cnt_r    <= CNT_ZERO;
      lat_r    <= LAT_MAX_DEF;
      pass_b_r <= 1'b0;
      cmd_r    <= RCS_CMD_NOP;
      addr_r   <= ADDR_PAT_A;
      wdata_r  <= '0;
    end else begin
      state_r  <= state_nxt;
      cnt_r    <= cnt_nxt;
      lat_r    <= lat_nxt;
      pass_b_r <= pass_b_nxt;
      cmd_r    <= cmd_nxt;
      addr_r   <= addr_nxt;
      wdata_r  <= wdata_nxt;
    end
  end

  // ************************************************************
  // ** outputs
  // ************************************************************
  logic own_ctl;
  assign own_ctl = (state_r == S_DONE);

  assign phy_cmd   = own_ctl ? ctl_cmd   : cmd_r;
  assign phy_addr  = own_ctl ? ctl_addr  : addr_r;
  assign phy_wdata = own_ctl ? ctl_wdata : wdata_r;

  assign read_valid_fifo_wr_ptr     = dp.vptr;
  assign rdfifo_wr_en     = rd_valid;
  assign rdfifo_ptr_reset = fifo_rst;
  assign latency_fifo_rd_en      = own_ctl & rd_valid;
  assign read_latency     = lat_r;
  assign seq_busy         = ~own_ctl;
  assign cal_success      = own_ctl;
  assign cal_fail         = (state_r == S_FAIL);
endmodule // rcs_seq
`default_nettype wire

// file: rcs_seq_checker.sv
`timescale 1ns/10ps
`default_nettype none
module rcs_seq_checker
  import rcs_pkg::*;
#(
  parameter int               STABLE_CYCLES = STABLE_CYC,
  parameter logic [LAT_W-1:0] LAT_MIN       = LAT_MIN_DEF
)(
  // clock and reset
  input wire logic              ref_clk,
  input wire logic              reset,
  // command sides
  input wire logic [1:0]        ctl_cmd,
  input wire logic [ADDR_W-1:0] ctl_addr,
  input wire logic [DATA_W-1:0] ctl_wdata,
  input wire logic [1:0]        phy_cmd,
  input wire logic [ADDR_W-1:0] phy_addr,
  input wire logic [DATA_W-1:0] phy_wdata,
  // read datapath
  input wire logic              rd_valid,
  input wire logic [DATA_W-1:0] rd_data,
  input wire logic [VPTR_W-1:0] read_valid_fifo_wr_ptr,
  input wire logic              rdfifo_wr_en,
  input wire logic              rdfifo_ptr_reset,
  input wire logic              latency_fifo_rd_en,
  input wire logic [LAT_W-1:0]  read_latency,
  // status
  input wire logic              seq_busy,
  input wire logic              cal_success,
  input wire logic              cal_fail
);
  // *****
  // ** helper state
  // *****
  logic [CNT_W-1:0] cyc_r;
  logic [CNT_W-1:0] cyc_nxt;
  logic             seen_r;
  logic             seen_nxt;
  always_comb begin
    cyc_nxt  = (cyc_r == 16'hFFFF) ? cyc_r : cyc_r + CNT_ONE;
    seen_nxt = seen_r | (phy_cmd != RCS_CMD_NOP);
    if (reset) begin
      cyc_nxt  = CNT_ZERO;
      seen_nxt = 1'b0;
    end
  end
  always_ff @(posedge ref_clk) begin
    cyc_r  <= cyc_nxt;
    seen_r <= seen_nxt;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // *****
  // ** properties
  // *****
  sequence s_wr_a;
    phy_cmd == RCS_CMD_WRITE && phy_addr == ADDR_PAT_A &&
      phy_wdata == 16'hAAAA;
  endsequence
  sequence s_wr_b;
    phy_cmd == RCS_CMD_WRITE && phy_addr == ADDR_PAT_B &&
      phy_wdata == 16'h5555;
  endsequence
  sequence s_rd_b;
    phy_cmd == RCS_CMD_READ && phy_addr == ADDR_PAT_B;
  endsequence
  property p_reset_state;
    disable iff (1'b0)
    reset |=> phy_cmd == RCS_CMD_NOP && seq_busy && !cal_success &&
      !cal_fail && read_latency == LAT_MAX_DEF && read_valid_fifo_wr_ptr == VPTR_ZERO;
  endproperty
  property p_stable_wait;
    (seq_busy && phy_cmd != RCS_CMD_NOP) |-> cyc_r >= CNT_W'(STABLE_CYCLES);
  endproperty
  property p_write_order;
    (phy_cmd != RCS_CMD_NOP && !seen_r) |-> s_wr_a ##2 s_wr_b;
  endproperty
  property p_read_gap;
    (seq_busy && phy_cmd == RCS_CMD_READ && phy_addr == ADDR_PAT_A &&
      read_latency == LAT_MAX_DEF) |=> (phy_cmd == RCS_CMD_NOP)[*2] ##1 s_rd_b;
  endproperty
  property p_owned;
    (seq_busy && phy_cmd != RCS_CMD_NOP) |-> phy_addr <= ADDR_PAT_B;
  endproperty
  property p_vptr_step;
    $changed(read_valid_fifo_wr_ptr) |->
      seq_busy && read_valid_fifo_wr_ptr == VPTR_W'($past(read_valid_fifo_wr_ptr) + VPTR_STEP);
  endproperty
  property p_lat_start;
    rdfifo_ptr_reset |-> read_latency == LAT_MAX_DEF ##[1:16] s_rd_b;
  endproperty
  property p_lat_step;
    $changed(read_latency) |->
      read_latency == LAT_W'($past(read_latency) - LAT_STEP_DOWN) ||
      read_latency == LAT_W'($past(read_latency) + LAT_MARGIN) ||
      read_latency == LAT_MAX_DEF;
  endproperty
  property p_final;
    ($rose(cal_success) || $rose(cal_fail)) |->
      cal_success == (read_latency >= LAT_MIN) && cal_success != cal_fail;
  endproperty
  property p_terminal;
    (cal_success || cal_fail) |=> $stable(cal_success) && $stable(cal_fail);
  endproperty
  property p_release;
    cal_success |-> !seq_busy && phy_cmd == ctl_cmd &&
      phy_addr == ctl_addr && phy_wdata == ctl_wdata;
  endproperty
  property p_fifo_en;
    rdfifo_wr_en == rd_valid && latency_fifo_rd_en == (cal_success && rd_valid);
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("outputs not at reset values");
  a_stable_wait: assert property (p_stable_wait)
    else $error("command before memory stable");
  a_write_order: assert property (p_write_order)
    else $error("pattern writes wrong");
  a_read_gap: assert property (p_read_gap)
    else $error("valid phase read pair wrong");
  a_owned: assert property (p_owned)
    else $error("sequencer command to stray address");
  a_vptr_step: assert property (p_vptr_step)
    else $error("write pointer step wrong");
  a_lat_start: assert property (p_lat_start)
    else $error("latency phase start wrong");
  a_lat_step: assert property (p_lat_step)
    else $error("latency change wrong");
  a_final: assert property (p_final)
    else $error("terminal verdict wrong");
  a_terminal: assert property (p_terminal)
    else $error("terminal state left");
  a_release: assert property (p_release)
    else $error("controller not passed through");
  a_fifo_en: assert property (p_fifo_en)
    else $error("fifo enables wrong");
endmodule // rcs_seq_checker
bind rcs_seq rcs_seq_checker #(
  .STABLE_CYCLES(STABLE_CYCLES),
  .LAT_MIN      (LAT_MIN)
) u_chk (
  .ref_clk, .reset, .ctl_cmd, .ctl_addr, .ctl_wdata, .phy_cmd, .phy_addr,
  .phy_wdata, .rd_valid, .rd_data, .read_valid_fifo_wr_ptr, .rdfifo_wr_en,
  .rdfifo_ptr_reset, .latency_fifo_rd_en, .read_latency, .seq_busy, .cal_success,
  .cal_fail
);
`default_nettype wire

// file: rcs_vptr.sv
`timescale 1ns/10ps
`default_nettype none
// ************************************************************
// ** read valid fifo write pointer
// ************************************************************
module rcs_vptr
  import rcs_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // link
  rcs_dp_if.ptr    dp
);
  logic [VPTR_W-1:0] vptr_r;
  logic [VPTR_W-1:0] vptr_nxt;

  always_comb begin
    vptr_nxt = vptr_r;
    if (dp.vptr_clr) begin
      vptr_nxt = VPTR_ZERO;
    end else if (dp.vptr_inc) begin
      vptr_nxt = vptr_r + VPTR_STEP;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      vptr_r <= VPTR_ZERO;
    end else begin
      vptr_r <= vptr_nxt;
    end
  end

  assign dp.vptr = vptr_r;
endmodule // rcs_vptr
`default_nettype wire

// file: read_calibration_sequencer_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module read_calibration_sequencer_tb_top;
  import rcs_pkg::*;
  localparam int STB = 20;
  // raised minimum so that short latency needs end in the error state
  localparam logic [LAT_W-1:0] LMIN = 5'h04;
  logic              ref_clk;
  logic              reset;
  logic [1:0]        ctl_cmd;
  logic [ADDR_W-1:0] ctl_addr;
  logic [DATA_W-1:0] ctl_wdata;
  logic [1:0]        phy_cmd;
  logic [ADDR_W-1:0] phy_addr;
  logic [DATA_W-1:0] phy_wdata;
  logic              rd_valid;
  logic [DATA_W-1:0] rd_data;
  logic [VPTR_W-1:0] read_valid_fifo_wr_ptr;
  logic              rdfifo_wr_en;
  logic              rdfifo_ptr_reset;
  logic              latency_fifo_rd_en;
  logic [LAT_W-1:0]  read_latency;
  logic              seq_busy;
  logic              cal_success;
  logic              cal_fail;
  logic [VPTR_W-1:0] vptr_need;
  logic [5:0]        lat_need;
  logic [31:0]       rv;
  int                n_mismatch;
  int                samples_checked;
  int                seed;
  rcs_seq #(.STABLE_CYCLES(STB), .LAT_MIN(LMIN)) DUT (
    .ref_clk, .reset, .ctl_cmd, .ctl_addr, .ctl_wdata, .phy_cmd, .phy_addr,
    .phy_wdata, .rd_valid, .rd_data, .read_valid_fifo_wr_ptr, .rdfifo_wr_en,
    .rdfifo_ptr_reset, .latency_fifo_rd_en, .read_latency, .seq_busy,
    .cal_success, .cal_fail
  );
  rcs_phy_model u_phy (
    .ref_clk, .reset, .phy_cmd, .phy_addr, .phy_wdata, .read_valid_fifo_wr_ptr,
    .read_latency, .rdfifo_ptr_reset, .vptr_need, .lat_need, .rd_valid,
    .rd_data
  );
  // *****
  // ** helpers
  // *****
  function automatic logic [LAT_W-1:0] exp_lat(input logic [5:0] need);
    return (need > 6'h1D) ? 5'h1F : LAT_W'(need + 6'h02);
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic run_cal(input logic [VPTR_W-1:0] vp,
                         input logic [5:0] ln, input bit abort);
    int          n;
    logic [31:0] v;
    bit          exp_pass;
    reset <= 1'b1;
    repeat (6) @(posedge ref_clk);
    vptr_need <= vp;
    lat_need  <= ln;
    reset     <= 1'b0;
    if (abort) begin
      repeat (40) @(posedge ref_clk);
      reset <= 1'b1;
      repeat (2) @(posedge ref_clk);
      reset <= 1'b0;
    end
    n = 0;
    while (cal_success !== 1'b1 && cal_fail !== 1'b1 && n < 6000) begin
      @(posedge ref_clk);
      ctl_cmd   <= RCS_CMD_NOP;
      ctl_addr  <= ADDR_W'($random(seed));
      ctl_wdata <= DATA_W'($random(seed));
      n++;
    end
    @(negedge ref_clk);
    exp_pass = (exp_lat(ln) >= LMIN);
    check({cal_success, cal_fail, seq_busy},
          exp_pass ? 3'h4 : 3'h3);
    check(read_latency, exp_lat(ln));
    check(read_valid_fifo_wr_ptr, vp);
    repeat (12) begin
      @(posedge ref_clk);
      v = $random(seed);
      ctl_cmd   <= (v[1:0] == 2'h3) ? 2'h2 : v[1:0];
      ctl_addr  <= v[15:8];
      ctl_wdata <= v[31:16];
      @(negedge ref_clk);
      if (exp_pass) begin
        check({phy_cmd, phy_addr, phy_wdata},
              {ctl_cmd, ctl_addr, ctl_wdata});
      end else begin
        check(phy_cmd, RCS_CMD_NOP);
      end
      check({latency_fifo_rd_en, rdfifo_wr_en},
            {exp_pass & rd_valid, rd_valid});
    end
    @(posedge ref_clk);
    ctl_cmd <= RCS_CMD_NOP;
  endtask
  // *****
  // ** clock, sequence, watchdog
  // *****
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    reset           = 1'b1;
    ctl_cmd         = RCS_CMD_NOP;
    ctl_addr        = 8'h00;
    ctl_wdata       = 16'h0000;
    vptr_need       = 4'h0;
    lat_need        = 6'h01;
    n_mismatch      = 0;
    samples_checked = 0;
    seed            = 32'h3435;
    run_cal(4'h0, 6'h01, 1'b0);
    run_cal(4'h6, 6'h20, 1'b1);
    run_cal(4'h2, 6'h1F, 1'b0);
    repeat (4) begin
      rv = $random(seed);
      run_cal({1'b0, rv[1:0], 1'b0}, 6'h01 + {1'b0, rv[7:3]}, 1'b0);
    end
    finish_test();
  end
  initial begin
    repeat (60000) @(posedge ref_clk);
    n_mismatch++;
    finish_test();
  end
endmodule // read_calibration_sequencer_tb_top
`default_nettype wire
